// [design/clkgen_top.v]
// Purpose: prescaled periodic clock generator with Wishbone registers
// Assumes: classic Wishbone, 32-bit data, pin input synchronous
// Notes: pin is open-drain, only ever pulled low
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
`include "clkgen_defs.vh"

module clkgen_top #(
    parameter CNT_W = 9
) (
    input wire CLOCK_I,
    input wire SRST_I,
    input wire CYC_I,
    input wire STB_I,
    input wire WE_I,
    input wire [7:0] ADR_I,
    input wire [3:0] SEL_I,
    input wire [31:0] DAT_I,
    output wire [31:0] DAT_O,
    output wire ACK_O,
    output wire IRQ_O,
    input wire CLK_PIN_I,
    output wire CLK_PIN_O,
    output wire CLK_PIN_OE_O
);

    reg ack_q;
    reg [31:0] dat_q;
    reg gen_en_q;
    reg drv_en_q;
    reg irq_en_q;
    reg [1:0] div_sel_q;
    reg pre_sel_q;
    reg tick_flag_q;
    reg pin_level_q;
    reg pin_prev_q;
    reg [1:0] evt_q;
    reg [1:0] msk_q;
    reg [7:0] csr_rd;
    reg [31:0] rd_mux;
    wire access;
    wire wr_low;
    wire [5:0] word;
    wire gen_level;
    wire irq_phase;
    reg tick_clr;
    reg [1:0] evt_set;
    reg [1:0] evt_clr;
    wire csr_wr;
    wire msk_wr;
    wire rd_take;
    reg [1:0] bus_state_q;
    reg [1:0] bus_state_d;
    reg ack_d;
    reg [31:0] dat_d;
    reg gen_en_d;
    reg drv_en_d;
    reg irq_en_d;
    reg [1:0] div_sel_d;
    reg pre_sel_d;
    reg tick_flag_d;
    reg [1:0] evt_d;
    reg [1:0] msk_d;
    reg pin_level_d;
    reg pin_prev_d;
    reg watch_q;

    // one-hot bus phases
    localparam [1:0] BUS_IDLE = 2'b01;
    localparam [1:0] BUS_ACK = 2'b10;

    function is_reg;
        input [5:0] w;
        input [5:0] idx;
        begin
            is_reg = (w == idx);
        end
    endfunction

    // set beats a write-one clear landing in the same cycle
    function sticky_next;
        input cur;
        input set;
        input clr;
        begin
            sticky_next = set || (cur && !clr);
        end
    endfunction

    // one access per strobe cycle with ack low, answered the following cycle
    assign access = CYC_I && STB_I && !ack_q;
    assign wr_low = access && WE_I && SEL_I[0];
    assign word = ADR_I[7:2];
    assign rd_take = access && !WE_I;
    assign csr_wr = wr_low && is_reg(word, `CG_CSR_IDX);
    assign msk_wr = wr_low && is_reg(word, `CG_MSK_IDX);

    // counters restart from zero each time the generator is enabled
    clkgen_divider #(
        .CNT_W(CNT_W)
    ) u_div (
        .clk_i(CLOCK_I),
        .srst_i(SRST_I),
        .run_i(gen_en_q),
        .pre_sel_i(pre_sel_q),
        .div_sel_i(div_sel_q),
        .level_o(gen_level),
        .irq_phase_o(irq_phase)
    );

    always @* begin
        csr_rd = `CG_CSR_RESET;
        csr_rd[`CG_GEN_EN_BIT] = gen_en_q;
        csr_rd[`CG_DRV_EN_BIT] = drv_en_q;
        csr_rd[`CG_IRQ_EN_BIT] = irq_en_q;
        csr_rd[`CG_DIV_HI_BIT:`CG_DIV_LO_BIT] = div_sel_q;
        csr_rd[`CG_PRE_BIT] = pre_sel_q;
        csr_rd[`CG_TICK_BIT] = tick_flag_q;
        csr_rd[`CG_PIN_BIT] = pin_level_q;
    end

    always @* begin
        rd_mux = 32'h00000000;
        if (is_reg(word, `CG_CSR_IDX)) begin
            rd_mux = {24'h000000, csr_rd};
        end else if (is_reg(word, `CG_EVT_IDX)) begin
            rd_mux = {30'h00000000, evt_q};
        end else if (is_reg(word, `CG_MSK_IDX)) begin
            rd_mux = {30'h00000000, msk_q};
        end
    end

    always @* begin
        tick_clr = 1'b0;
        evt_clr = 2'h0;
        if (csr_wr) begin
            tick_clr = DAT_I[`CG_TICK_BIT];
        end
        if (wr_low && is_reg(word, `CG_EVT_IDX)) begin
            evt_clr = DAT_I[1:0];
        end
    end

    // edges only count while the level is being watched
    always @* begin
        evt_set = 2'h0;
        if (gen_en_q) begin
            evt_set[`CG_EVT_FALL_BIT] = pin_prev_q && !pin_level_q;
            evt_set[`CG_EVT_RISE_BIT] = !pin_prev_q && pin_level_q;
        end
    end

    // the ack phase refuses a new take, so a held strobe is served
    // every other cycle
    always @* begin
        bus_state_d = bus_state_q;
        ack_d = 1'b0;
        case (bus_state_q)
            BUS_IDLE: begin
                if (access) begin
                    bus_state_d = BUS_ACK;
                    ack_d = 1'b1;
                end
            end
            BUS_ACK: begin
                bus_state_d = BUS_IDLE;
            end
            default: begin
                bus_state_d = BUS_IDLE;
            end
        endcase
    end

    // read data holds until the next read; writes leave it alone
    always @* begin
        dat_d = dat_q;
        if (rd_take) begin
            dat_d = rd_mux;
        end
    end

    // unmapped words and writes without the low lane fall through
    always @* begin
        gen_en_d = gen_en_q;
        drv_en_d = drv_en_q;
        irq_en_d = irq_en_q;
        div_sel_d = div_sel_q;
        pre_sel_d = pre_sel_q;
        msk_d = msk_q;
        if (csr_wr) begin
            gen_en_d = DAT_I[`CG_GEN_EN_BIT];
            drv_en_d = DAT_I[`CG_DRV_EN_BIT];
            irq_en_d = DAT_I[`CG_IRQ_EN_BIT];
            // taken even while running; glitches are software's risk
            div_sel_d = DAT_I[`CG_DIV_HI_BIT:`CG_DIV_LO_BIT];
            pre_sel_d = DAT_I[`CG_PRE_BIT];
        end
        if (msk_wr) begin
            msk_d = DAT_I[1:0];
        end
    end

    always @* begin
        tick_flag_d = sticky_next(tick_flag_q, irq_phase, tick_clr);
    end

    always @* begin
        evt_d[`CG_EVT_FALL_BIT] = sticky_next(evt_q[`CG_EVT_FALL_BIT],
            evt_set[`CG_EVT_FALL_BIT], evt_clr[`CG_EVT_FALL_BIT]);
        evt_d[`CG_EVT_RISE_BIT] = sticky_next(evt_q[`CG_EVT_RISE_BIT],
            evt_set[`CG_EVT_RISE_BIT], evt_clr[`CG_EVT_RISE_BIT]);
    end

    // holds the last seen level once disabled; the first enabled sample
    // seeds both taps, so switching on never reports a stale edge
    always @* begin
        pin_level_d = pin_level_q;
        pin_prev_d = pin_level_q;
        if (gen_en_q) begin
            pin_level_d = CLK_PIN_I;
            if (!watch_q) begin
                pin_prev_d = CLK_PIN_I;
            end
        end
    end

    // the registers below only copy next values; every decision
    // sits in the combinational blocks above
    always @(posedge CLOCK_I) begin
        if (SRST_I) begin
            bus_state_q <= BUS_IDLE;
            ack_q <= 1'b0;
        end else begin
            bus_state_q <= bus_state_d;
            ack_q <= ack_d;
        end
    end

    always @(posedge CLOCK_I) begin
        if (SRST_I) begin
            dat_q <= 32'h00000000;
        end else begin
            dat_q <= dat_d;
        end
    end

    always @(posedge CLOCK_I) begin
        if (SRST_I) begin
            gen_en_q <= 1'b0;
            drv_en_q <= 1'b0;
            irq_en_q <= 1'b0;
            div_sel_q <= `CG_DIV1;
            pre_sel_q <= 1'b0;
        end else begin
            gen_en_q <= gen_en_d;
            drv_en_q <= drv_en_d;
            irq_en_q <= irq_en_d;
            div_sel_q <= div_sel_d;
            pre_sel_q <= pre_sel_d;
        end
    end

    always @(posedge CLOCK_I) begin
        if (SRST_I) begin
            msk_q <= `CG_MSK_RESET;
        end else begin
            msk_q <= msk_d;
        end
    end

    always @(posedge CLOCK_I) begin
        if (SRST_I) begin
            tick_flag_q <= 1'b0;
        end else begin
            tick_flag_q <= tick_flag_d;
        end
    end

    always @(posedge CLOCK_I) begin
        if (SRST_I) begin
            evt_q <= `CG_EVT_RESET;
        end else begin
            evt_q <= evt_d;
        end
    end

    always @(posedge CLOCK_I) begin
        if (SRST_I) begin
            pin_level_q <= 1'b0;
            pin_prev_q <= 1'b0;
            watch_q <= 1'b0;
        end else begin
            pin_level_q <= pin_level_d;
            pin_prev_q <= pin_prev_d;
            watch_q <= gen_en_q;
        end
    end

    assign DAT_O = dat_q;
    assign ACK_O = ack_q;
    assign IRQ_O = (tick_flag_q && irq_en_q) || (|(evt_q & msk_q));
    // never drives high: a slow external device may stretch the low
    assign CLK_PIN_O = 1'b0;
    assign CLK_PIN_OE_O = gen_en_q && drv_en_q && !gen_level;

endmodule // clkgen_top

// [design/clkgen_defs.vh]
// Purpose: constants of the prescaled open-drain clock generator
// Assumes: included by clkgen_top.v and clkgen_divider.v
// Notes: offsets are word indexes, byte address is four times the index
//
// Contract
// - pin level readable while enabled, reset clears
// - tick flag set by generator, write one clears
// - prescale select one gives 480, zero 160
// - source divide 00/01/10 gives 1/2/4
// - output rate is bus over product
// - tick irq enable gates the interrupt
// - output drive enable lets clock pull pin
// - generator enable runs the prescaler clock source
// - enabled pin acts as open-drain only
// - output and interrupt on different phases
// - pin level sampled every bus cycle while the generator is enabled
`ifndef CLKGEN_DEFS_VH
`define CLKGEN_DEFS_VH

// register word indexes
`define CG_CSR_IDX 6'h19
`define CG_EVT_IDX 6'h1A
`define CG_MSK_IDX 6'h1B

// control and status bit positions
`define CG_GEN_EN_BIT 0
`define CG_DRV_EN_BIT 1
`define CG_IRQ_EN_BIT 2
`define CG_DIV_LO_BIT 3
`define CG_DIV_HI_BIT 4
`define CG_PRE_BIT 5
`define CG_TICK_BIT 6
`define CG_PIN_BIT 7

// event status and mask bit positions
`define CG_EVT_FALL_BIT 0
`define CG_EVT_RISE_BIT 1

// reset values
`define CG_CSR_RESET 8'h00
`define CG_EVT_RESET 2'h0
`define CG_MSK_RESET 2'h0

// prescaler ratios and source divide codes
`define CG_PRE_LOW 9'h0A0
`define CG_PRE_HIGH 9'h1E0
`define CG_DIV1 2'h0
`define CG_DIV2 2'h1
`define CG_DIV4 2'h2

`endif

// [design/clkgen_divider.v]
// Purpose: source divider and two-phase prescaler
// Assumes: ratio settings stable while run is high
// Notes: output phase and interrupt phase a quarter period apart
`timescale 1ns/1ps
`include "clkgen_defs.vh"

module clkgen_divider #(
    parameter CNT_W = 9,
    parameter [CNT_W-1:0] PRE_LOW = `CG_PRE_LOW,
    parameter [CNT_W-1:0] PRE_HIGH = `CG_PRE_HIGH
) (
    input wire clk_i,
    input wire srst_i,
    input wire run_i,
    input wire pre_sel_i,
    input wire [1:0] div_sel_i,
    output wire level_o,
    output wire irq_phase_o
);

    reg [1:0] div_cnt_q;
    reg [CNT_W-1:0] pre_cnt_q;
    reg level_q;
    reg irq_phase_q;
    wire [1:0] div_last;
    wire [CNT_W-1:0] ratio;
    wire src_tick;
    reg [CNT_W-1:0] pre_cnt_d;

    function [1:0] div_limit;
        input [1:0] sel;
        begin
            case (sel)
                `CG_DIV1: div_limit = 2'h0;
                `CG_DIV2: div_limit = 2'h1;
                default: div_limit = 2'h3;
            endcase
        end
    endfunction

    assign div_last = div_limit(div_sel_i);
    assign ratio = pre_sel_i ? PRE_HIGH : PRE_LOW;
    // bus clock gated to the prescaler only while running
    assign src_tick = run_i && (div_cnt_q >= div_last);

    always @* begin
        pre_cnt_d = pre_cnt_q;
        if (!run_i) begin
            pre_cnt_d = {CNT_W{1'b0}};
        end else if (src_tick) begin
            // compare with >= so a ratio shrunk mid-count still wraps
            if (pre_cnt_q >= ratio - 1'b1) begin
                pre_cnt_d = {CNT_W{1'b0}};
            end else begin
                pre_cnt_d = pre_cnt_q + 1'b1;
            end
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            div_cnt_q <= 2'h0;
            pre_cnt_q <= {CNT_W{1'b0}};
            level_q <= 1'b1;
            irq_phase_q <= 1'b0;
        end else begin
            if (!run_i || src_tick) begin
                div_cnt_q <= 2'h0;
            end else begin
                div_cnt_q <= div_cnt_q + 2'h1;
            end
            pre_cnt_q <= pre_cnt_d;
            // high first half, low second half of the period
            // idle high, so switching on never opens with a pull
            level_q <= !run_i || (pre_cnt_d < (ratio >> 1));
            // interrupt phase sits mid high half, away from edges
            irq_phase_q <= src_tick && (pre_cnt_q == (ratio >> 2));
        end
    end

    assign level_o = level_q;
    assign irq_phase_o = irq_phase_q;

endmodule // clkgen_divider

// [verification/clkgen_checker.sv]
// Purpose: port checks of the clock generator
// Assumes: registers at the word indexes of the defs header
// Notes: shadows follow software writes only
`timescale 1ns/1ps
`include "clkgen_defs.vh"
module clkgen_checker #(
    parameter CNT_W = 9
) (
    input wire CLOCK_I,
    input wire SRST_I,
    input wire CYC_I,
    input wire STB_I,
    input wire WE_I,
    input wire [7:0] ADR_I,
    input wire [3:0] SEL_I,
    input wire [31:0] DAT_I,
    input wire [31:0] DAT_O,
    input wire ACK_O,
    input wire IRQ_O,
    input wire CLK_PIN_I,
    input wire CLK_PIN_O,
    input wire CLK_PIN_OE_O
);
    default clocking @(posedge CLOCK_I);
    endclocking
    default disable iff (SRST_I);
    wire take = CYC_I && STB_I && !ACK_O;
    wire wr = take && WE_I && SEL_I[0];
    reg [7:0] csr_q;
    reg [1:0] msk_q;
    always @(posedge CLOCK_I) begin
        if (SRST_I) begin
            csr_q <= 8'h00;
            msk_q <= 2'h0;
        end else if (wr && ADR_I[7:2] == `CG_CSR_IDX) begin
            csr_q <= DAT_I[7:0];
        end else if (wr && ADR_I[7:2] == `CG_MSK_IDX) begin
            msk_q <= DAT_I[1:0];
        end
    end
    AST_ACK_PULSE: assert property (ACK_O |=> !ACK_O)
        else $error("ack longer than one cycle");
    AST_ACK_TIME: assert property (take |=> ACK_O)
        else $error("ack late");
    AST_ACK_CAUSE: assert property (!(CYC_I && STB_I) |=> !ACK_O)
        else $error("ack without request");
    AST_OPEN_DRAIN: assert property (CLK_PIN_O == 1'b0)
        else $error("pin driven high");
    AST_OE_DRV: assert property (!csr_q[1] |-> !CLK_PIN_OE_O)
        else $error("pin pulled with drive off");
    AST_OE_EN: assert property (!csr_q[0] |-> !CLK_PIN_OE_O)
        else $error("pin pulled while halted");
    AST_OE_START: assert property ($rose(csr_q[0]) |-> !CLK_PIN_OE_O)
        else $error("pin pulled as the generator starts");
    AST_IRQ_MASK: assert property (!csr_q[2] && !msk_q |-> !IRQ_O)
        else $error("irq while masked");
    AST_PHASE: assert property ($rose(CLK_PIN_OE_O) |-> !$rose(IRQ_O))
        else $error("irq on output edge");
    AST_UNMAPPED: assert property (take && !WE_I && ADR_I == 8'h70
        |=> DAT_O == 32'h0)
        else $error("unmapped read not zero");
    cover property ($rose(CLK_PIN_OE_O));
    cover property ($rose(IRQ_O));
    cover property (wr && ADR_I[7:2] == `CG_CSR_IDX);
endmodule // clkgen_checker
bind clkgen_top clkgen_checker #(.CNT_W(CNT_W)) chk (
    .CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .CYC_I(CYC_I), .STB_I(STB_I),
    .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I),
    .DAT_O(DAT_O), .ACK_O(ACK_O), .IRQ_O(IRQ_O), .CLK_PIN_I(CLK_PIN_I),
    .CLK_PIN_O(CLK_PIN_O), .CLK_PIN_OE_O(CLK_PIN_OE_O)
);

// [verification/pin_partner.sv]
// Purpose: far device on the open-drain clock line
// Assumes: line has a pull-up
// Notes: device may hold the line low to stretch
`timescale 1ns/1ps
module pin_partner (
    input wire oe_i,
    input wire drv_i,
    input wire hold_i,
    output wire pin_o
);
    // pull-up wins unless some party pulls low
    assign pin_o = (oe_i ? drv_i : 1'b1) & !hold_i;
endmodule // pin_partner

// [verification/testbench.sv]
// Purpose: random and corner tests of the clock generator
// Assumes: pull-up on the pin, 20 MHz clock
// Notes: one full period is measured per divider setting
`timescale 1ns/1ps
module testbench;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg req = 1'b0;
    reg we = 1'b0;
    reg hold = 1'b0;
    reg [3:0] sel = 4'hF;
    reg [7:0] adr = 8'h00;
    reg [7:0] c;
    reg [31:0] wdat = 32'h0;
    reg [31:0] d;
    reg [1:0] ev;
    wire [31:0] rdat;
    wire ack, irq, pin, po, oe;
    int bad_count = 0;
    int samples_checked = 0;
    int n, k1, k2;
    reg p;
    clkgen_top dut (.CLOCK_I(clk), .SRST_I(rst), .CYC_I(req), .STB_I(req),
        .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat),
        .ACK_O(ack), .IRQ_O(irq), .CLK_PIN_I(pin), .CLK_PIN_O(po),
        .CLK_PIN_OE_O(oe));
    pin_partner far (.oe_i(oe), .drv_i(po), .hold_i(hold), .pin_o(pin));
    initial begin
        forever #25 clk = ~clk;
    end
    function int per(input [7:0] v);
        return (v[5] ? 480 : 160) * (v[4:3] == 2'h0 ? 1 : v[4] ? 4 : 2);
    endfunction
    task chk(input string nm, input [31:0] e, input [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task bus(input w, input [3:0] s, input [7:0] a, input [31:0] wd);
        int k;
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        sel <= s;
        adr <= a;
        wdat <= wd;
        @(posedge clk);
        for (k = 0; k < 20 && ack !== 1'b1; k++)
            @(posedge clk);
        d = rdat;
        req <= 1'b0;
        chk("ack", 1, ack);
    endtask
    // cycles while the pin output enable keeps value v
    task span(input v, output int k);
        for (k = 0; k < 4000 && oe === v; k++)
            @(posedge clk);
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #2000000;
        bad_count++;
        stop_test;
    end
    initial begin
        void'($urandom(56));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        bus(0, 4'hF, 8'h64, 0);
        chk("csr reset", 0, d);
        bus(1, 4'hE, 8'h64, 32'h3F);
        bus(1, 4'hF, 8'h70, 32'hFF);
        bus(0, 4'hF, 8'h70, 0);
        chk("unmapped", 0, d);
        bus(0, 4'hF, 8'h64, 0);
        chk("csr no sel", 0, d);
        for (n = 0; n < 8; n++) begin
            c = {2'b00, n[0], n[2:1], 3'b011};
            c[2] = $urandom % 2;
            bus(1, 4'hF, 8'h64, {24'h0, c & 8'hFE});
            bus(1, 4'hF, 8'h64, {24'h0, c});
            bus(0, 4'hF, 8'h64, 0);
            chk("csr rw", c[5:0], d[5:0]);
            span(0, k1);
            span(1, k1);
            span(0, k2);
            chk("pull time", per(c) / 2, k1);
            chk("period", per(c), k1 + k2);
            chk("irq", c[2], irq);
            bus(0, 4'hF, 8'h64, 0);
            chk("tick", 1, d[6]);
            bus(1, 4'hF, 8'h64, 32'h0);
            bus(1, 4'hF, 8'h64, 32'h40);
            bus(0, 4'hF, 8'h64, 0);
            chk("tick clr", 0, d[6]);
            chk("irq clr", 0, irq);
        end
        bus(1, 4'hF, 8'h64, 32'h01);
        bus(1, 4'hF, 8'h6C, 32'h3);
        bus(1, 4'hF, 8'h68, 32'h3);
        p = 1'b1;
        ev = 2'h0;
        for (n = 0; n < 10; n++) begin
            hold <= $urandom % 2;
            bus(0, 4'hF, 8'h64, 0);
            ev[0] = ev[0] | (p & hold);
            ev[1] = ev[1] | (!p & !hold);
            p = !hold;
            chk("pin flag", p, d[7]);
        end
        bus(0, 4'hF, 8'h68, 0);
        chk("events", ev, d);
        chk("event irq", |ev, irq);
        hold <= 1'b0;
        bus(1, 4'hF, 8'h68, 32'h3);
        bus(1, 4'hF, 8'h68, 32'h3);
        chk("irq off", 0, irq);
        stop_test;
    end
endmodule // testbench
